//--- logic/bxc_pkg.sv
// constants, carrier types and state enumerations for the bridge extension control registers
package bxc_pkg;

  // ==========================================================
  // register offsets (byte offsets in configuration space)
  localparam logic [7:0] OFF_BRIDGE_CTRL_HI = 8'h3f;
  localparam logic [7:0] OFF_BRIDGE_CTRL = 8'h3e;
  localparam logic [7:0] OFF_DIAG = 8'h41;
  localparam logic [7:0] OFF_ARB_LO = 8'h42;
  localparam logic [7:0] OFF_ARB_HI = 8'h43;
  localparam logic [7:0] OFF_SERR_MASK = 8'h64;
  localparam logic [7:0] OFF_GPIO_DATA = 8'h65;

  // ==========================================================
  // field positions
  localparam int BRIDGE_CTRL_SEC_RESET_BIT = 6;
  localparam int DIAG_RESET_BIT = 0;
  localparam int ARB_BRIDGE_BIT = 9;
  localparam int GPIO_HIGH_LSB = 4;
  localparam int GPIO_LOW_LSB = 0;
  localparam int GPIO_PINS = 4;

  // ==========================================================
  // reset values and writable masks
  localparam logic [15:0] ARB_RESET = 16'h0200;
  localparam logic [15:0] ARB_WRITABLE = 16'h03ff;
  localparam logic [7:0] SERR_MASK_RESET = 8'h00;
  localparam logic [7:0] SERR_MASK_WRITABLE = 8'h7e;
  localparam logic [7:0] GPIO_DATA_RESET = 8'h00;
  localparam logic [3:0] GPIO_DIR_RESET = 4'h0;

  // ==========================================================
  // arbiter shape and self reset timing
  localparam int NUM_REQ = 10;
  localparam logic [3:0] ARB_PTR_RESET = 4'h9;
  localparam int SELF_RESET_NS = 400;
  localparam int CLOCK_PERIOD_NS = 25;
  localparam logic [7:0] SELF_RESET_CYCLES = 8'((SELF_RESET_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

  // ==========================================================
  // carriers
  typedef struct packed {
    logic write;
    logic [5:0] dword;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } bxc_cfg_req_t;

  // bit order matches event mask bits 6 down to 1
  typedef struct packed {
    logic rd_timeout;
    logic wr_timeout;
    logic pw_master_abort;
    logic pw_target_abort;
    logic pw_timeout;
    logic pw_parity;
  } bxc_err_event_t;

  typedef enum logic [1:0] {
    DIAG_IDLE,
    DIAG_SET_HOLD,
    DIAG_SELF_RESET
  } bxc_diag_state_t;

endpackage

//--- logic/bxc_tier_arbiter.sv
// two-tier rotational arbiter for the secondary bus requesters
`timescale 1ns/1ps
module bxc_tier_arbiter (
  // clock, resets and clock enable
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic soft_reset,
  // requests and tier placement, bit 9 is the bridge itself
  input wire logic [9:0] req,
  input wire logic [9:0] high_tier,
  // one-hot grant
  output logic [9:0] grant_reg
);

  logic [9:0] grant_next;
  logic [3:0] ptr_hi_reg;
  logic [3:0] ptr_hi_next;
  logic [3:0] ptr_lo_reg;
  logic [3:0] ptr_lo_next;
  logic [9:0] cand_hi;
  logic [9:0] cand_lo;
  logic [3:0] win;

  // ==========================================================
  // first candidate after the last winner, wrapping round
  function automatic logic [3:0] pick_next(input logic [9:0] cand, input logic [3:0] last);
    logic [3:0] idx;
    logic found;
    pick_next = last;
    found = 1'b0;
    for (int i = 1; i <= bxc_pkg::NUM_REQ; i++) begin
      idx = 4'((int'(last) + i) % bxc_pkg::NUM_REQ);
      if (!found && cand[idx]) begin
        pick_next = idx;
        found = 1'b1;
      end
    end
  endfunction

  // ==========================================================
  // grant selection
  always_comb begin
    grant_next = grant_reg;
    ptr_hi_next = ptr_hi_reg;
    ptr_lo_next = ptr_lo_reg;
    cand_hi = req & high_tier;
    cand_lo = req & ~high_tier;
    win = 4'h0;
    if (soft_reset) begin
      grant_next = '0;
      ptr_hi_next = bxc_pkg::ARB_PTR_RESET;
      ptr_lo_next = bxc_pkg::ARB_PTR_RESET;
    end else if ((grant_reg & req) == 10'h000) begin
      // high tier always wins, rotation keeps each tier fair [R5]
      if (|cand_hi) begin
        win = pick_next(cand_hi, ptr_hi_reg);
        ptr_hi_next = win;
        grant_next = 10'h001 << win;
      end else if (|cand_lo) begin
        win = pick_next(cand_lo, ptr_lo_reg);
        ptr_lo_next = win;
        grant_next = 10'h001 << win;
      end else begin
        grant_next = '0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      grant_reg <= '0;
      ptr_hi_reg <= bxc_pkg::ARB_PTR_RESET;
      ptr_lo_reg <= bxc_pkg::ARB_PTR_RESET;
    end else if (ce) begin
      grant_reg <= grant_next;
      ptr_hi_reg <= ptr_hi_next;
      ptr_lo_reg <= ptr_lo_next;
    end
  end

endmodule

//--- logic/bxc_ext_regs.sv
// extension control registers: self reset, arbiter tiers, error event mask, gpio output data
// How it works
// [R1] writing one to diagnostic bit 0 sets bridge control bit 6, then self resets
// [R2] the self reset resets this block and holds the secondary bus in reset
// [R3] bridge control bit 6 survives the self reset and stays set
// [R4] diagnostic bit 0 clears itself; diagnostic bits 7 to 1 read zero
// [R5] arbiter has two tiers, rotation within each, high tier favoured
// [R6] arbiter bit 9 places the bridge in low or high tier, resets to one
// [R7] arbiter bits 8 to 0 place grant lines 8 to 0, reset to zero
// [R8] arbiter bits 15 to 10 read zero
// [R9] mask bit 6 clear lets a delayed read time-out raise system error
// [R10] mask bit 5 clear lets a delayed write time-out raise system error
// [R11] mask bit 4 clear lets a posted write master abort raise system error
// [R12] mask bit 3 clear lets a posted write target abort raise system error
// [R13] mask bit 2 clear lets a posted write time-out raise system error
// [R14] mask bit 1 clear lets a posted write parity error raise system error
// [R15] event mask resets to zero; bits 7 and 0 read zero
// [R16] a one in gpio data bits 7 to 4 drives pins 3 to 0 high
// [R17] a one in gpio data bits 3 to 0 drives pins 3 to 0 low
// [R18] with both high and low set for a pin, low wins
// [R19] output data does nothing on input pins; data register resets to zero
// [R20] after reset every gpio pin is an input until configured
// [R21] system error needs the event, its clear mask bit and the global enable
`timescale 1ns/1ps
module bxc_ext_regs (
  // clock, reset, clock enable
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  // configuration access
  input wire logic cfg_valid,
  input wire bxc_pkg::bxc_cfg_req_t cfg_req,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  // secondary arbitration
  input wire logic [8:0] secondary_req,
  input wire logic bridge_req,
  output logic [8:0] secondary_grant,
  output logic bridge_grant,
  // system error
  input wire logic serr_global_enable,
  input wire bxc_pkg::bxc_err_event_t err_event,
  output logic primary_system_error_out,
  // gpio
  input wire logic [3:0] gpio_dir_output,
  output logic [3:0] gpio_out,
  output logic [3:0] gpio_oe,
  // resets driven out
  output logic self_reset_out,
  output logic secondary_bus_reset_out
);

  // ==========================================================
  // state
  bxc_pkg::bxc_diag_state_t diag_state_reg;
  bxc_pkg::bxc_diag_state_t diag_state_next;
  logic [7:0] diag_count_reg;
  logic [7:0] diag_count_next;
  logic sec_reset_bit_reg;
  logic sec_reset_bit_next;
  logic [15:0] arb_tier_reg;
  logic [15:0] arb_tier_next;
  logic [7:0] serr_mask_reg;
  logic [7:0] serr_mask_next;
  logic [7:0] gpio_data_reg;
  logic [7:0] gpio_data_next;
  logic [3:0] gpio_level_reg;
  logic [3:0] gpio_level_next;
  logic [3:0] gpio_oe_reg;
  logic [3:0] gpio_oe_next;
  logic [3:0] gpio_out_reg;
  logic [3:0] gpio_out_next;
  logic serr_reg;
  logic serr_next;
  logic self_reset_reg;
  logic self_reset_next;
  logic sec_bus_reset_reg;
  logic sec_bus_reset_next;
  logic cfg_ack_reg;
  logic cfg_ack_next;
  logic [31:0] cfg_rdata_reg;
  logic [31:0] cfg_rdata_next;
  logic soft_rst;
  logic [9:0] grant_vec;
  logic [5:0] unmasked;
  logic [3:0] hi_bits;
  logic [3:0] lo_bits;
  logic [7:0] wbyte;
  logic [7:0] ctrl_byte;
  logic [7:0] diag_byte;

  // ==========================================================
  // byte lane helpers
  function automatic logic wr_hit(input logic v, input bxc_pkg::bxc_cfg_req_t r, input logic [7:0] off);
    wr_hit = v && r.write && (r.dword == off[7:2]) && r.byte_en[off[1:0]];
  endfunction

  function automatic logic [7:0] lane_data(input bxc_pkg::bxc_cfg_req_t r, input logic [7:0] off);
    lane_data = r.wdata[8 * int'(off[1:0]) +: 8];
  endfunction

  function automatic logic [31:0] place(input logic [5:0] dw, input logic [7:0] off, input logic [7:0] val);
    place = (dw == off[7:2]) ? (32'(val) << (8 * int'(off[1:0]))) : 32'h0000_0000;
  endfunction

  assign soft_rst = (diag_state_reg == bxc_pkg::DIAG_SELF_RESET);

  // ==========================================================
  // diagnostic self reset sequence
  always_comb begin
    diag_state_next = diag_state_reg;
    diag_count_next = diag_count_reg;
    sec_reset_bit_next = sec_reset_bit_reg;
    self_reset_next = 1'b0;
    sec_bus_reset_next = sec_reset_bit_reg;
    ctrl_byte = lane_data(cfg_req, bxc_pkg::OFF_BRIDGE_CTRL);
    diag_byte = lane_data(cfg_req, bxc_pkg::OFF_DIAG);
    unique case (diag_state_reg)
      bxc_pkg::DIAG_IDLE: begin
        if (wr_hit(cfg_valid, cfg_req, bxc_pkg::OFF_BRIDGE_CTRL)) begin
          sec_reset_bit_next = ctrl_byte[bxc_pkg::BRIDGE_CTRL_SEC_RESET_BIT];
        end
        if (wr_hit(cfg_valid, cfg_req, bxc_pkg::OFF_DIAG) && diag_byte[bxc_pkg::DIAG_RESET_BIT]) begin
          diag_state_next = bxc_pkg::DIAG_SET_HOLD; // [R1]
        end
      end
      bxc_pkg::DIAG_SET_HOLD: begin
        // bit 6 is raised on the same edge that the self reset begins
        sec_reset_bit_next = 1'b1; // [R1]
        diag_count_next = bxc_pkg::SELF_RESET_CYCLES;
        diag_state_next = bxc_pkg::DIAG_SELF_RESET;
        self_reset_next = 1'b1;
        sec_bus_reset_next = 1'b1;
      end
      bxc_pkg::DIAG_SELF_RESET: begin
        // bit 6 is not touched here, only rstn or software clears it [R3]
        self_reset_next = 1'b1; // [R2]
        sec_bus_reset_next = 1'b1; // [R2]
        diag_count_next = diag_count_reg - 8'h01;
        if (diag_count_reg == 8'h01) begin
          diag_state_next = bxc_pkg::DIAG_IDLE; // [R4]
          self_reset_next = 1'b0;
        end
      end
      default: begin
        diag_state_next = bxc_pkg::DIAG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      diag_state_reg <= bxc_pkg::DIAG_IDLE;
      diag_count_reg <= 8'h00;
      sec_reset_bit_reg <= 1'b0;
      self_reset_reg <= 1'b0;
      sec_bus_reset_reg <= 1'b0;
    end else if (ce) begin
      diag_state_reg <= diag_state_next;
      diag_count_reg <= diag_count_next;
      sec_reset_bit_reg <= sec_reset_bit_next;
      self_reset_reg <= self_reset_next;
      sec_bus_reset_reg <= sec_bus_reset_next;
    end
  end

  // ==========================================================
  // arbiter tier, event mask and gpio registers
  always_comb begin
    arb_tier_next = arb_tier_reg;
    serr_mask_next = serr_mask_reg;
    gpio_data_next = gpio_data_reg;
    gpio_level_next = gpio_level_reg;
    // direction follows the direction register, all inputs out of reset [R20]
    gpio_oe_next = gpio_dir_output;
    wbyte = lane_data(cfg_req, bxc_pkg::OFF_GPIO_DATA);
    hi_bits = wbyte[bxc_pkg::GPIO_HIGH_LSB +: bxc_pkg::GPIO_PINS];
    lo_bits = wbyte[bxc_pkg::GPIO_LOW_LSB +: bxc_pkg::GPIO_PINS];
    if (soft_rst) begin
      arb_tier_next = bxc_pkg::ARB_RESET; // [R2]
      serr_mask_next = bxc_pkg::SERR_MASK_RESET;
      gpio_data_next = bxc_pkg::GPIO_DATA_RESET;
      gpio_level_next = 4'h0;
      gpio_oe_next = bxc_pkg::GPIO_DIR_RESET;
    end else begin
      if (wr_hit(cfg_valid, cfg_req, bxc_pkg::OFF_ARB_LO)) begin
        arb_tier_next[7:0] = lane_data(cfg_req, bxc_pkg::OFF_ARB_LO); // [R7]
      end
      if (wr_hit(cfg_valid, cfg_req, bxc_pkg::OFF_ARB_HI)) begin
        // upper bits are held at zero [R8]
        arb_tier_next[15:8] = lane_data(cfg_req, bxc_pkg::OFF_ARB_HI) & bxc_pkg::ARB_WRITABLE[15:8]; // [R6]
      end
      if (wr_hit(cfg_valid, cfg_req, bxc_pkg::OFF_SERR_MASK)) begin
        serr_mask_next = lane_data(cfg_req, bxc_pkg::OFF_SERR_MASK) & bxc_pkg::SERR_MASK_WRITABLE; // [R15]
      end
      if (wr_hit(cfg_valid, cfg_req, bxc_pkg::OFF_GPIO_DATA)) begin
        gpio_data_next = wbyte;
        for (int i = 0; i < bxc_pkg::GPIO_PINS; i++) begin
          // input pins ignore the write; zeros leave the level alone [R19]
          if (gpio_oe_reg[i] && lo_bits[i]) begin
            gpio_level_next[i] = 1'b0; // [R17] [R18]
          end else if (gpio_oe_reg[i] && hi_bits[i]) begin
            gpio_level_next[i] = 1'b1; // [R16]
          end
        end
      end
    end
    gpio_out_next = gpio_level_next & gpio_oe_next; // [R19]
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      arb_tier_reg <= bxc_pkg::ARB_RESET; // [R6] [R7]
      serr_mask_reg <= bxc_pkg::SERR_MASK_RESET; // [R15]
      gpio_data_reg <= bxc_pkg::GPIO_DATA_RESET; // [R19]
      gpio_level_reg <= 4'h0;
      gpio_oe_reg <= bxc_pkg::GPIO_DIR_RESET; // [R20]
      gpio_out_reg <= 4'h0;
    end else if (ce) begin
      arb_tier_reg <= arb_tier_next;
      serr_mask_reg <= serr_mask_next;
      gpio_data_reg <= gpio_data_next;
      gpio_level_reg <= gpio_level_next;
      gpio_oe_reg <= gpio_oe_next;
      gpio_out_reg <= gpio_out_next;
    end
  end

  // ==========================================================
  // system error gating
  always_comb begin
    // events are pulses from the datapath; a masked event is dropped, not deferred
    unmasked = err_event & ~serr_mask_reg[6:1]; // [R9] [R10] [R11] [R12] [R13] [R14]
    serr_next = serr_global_enable && (|unmasked) && !soft_rst; // [R21]
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      serr_reg <= 1'b0;
    end else if (ce) begin
      serr_reg <= serr_next;
    end
  end

  // ==========================================================
  // configuration read and acknowledge
  always_comb begin
    cfg_ack_next = cfg_valid;
    cfg_rdata_next = 32'h0000_0000;
    if (cfg_valid && !cfg_req.write) begin
      // diagnostic byte always reads zero [R4]
      cfg_rdata_next =
        place(cfg_req.dword, bxc_pkg::OFF_BRIDGE_CTRL,
              8'({7'h00, sec_reset_bit_reg} << bxc_pkg::BRIDGE_CTRL_SEC_RESET_BIT)) |
        place(cfg_req.dword, bxc_pkg::OFF_ARB_LO, arb_tier_reg[7:0]) |
        place(cfg_req.dword, bxc_pkg::OFF_ARB_HI, arb_tier_reg[15:8] & bxc_pkg::ARB_WRITABLE[15:8]) | // [R8]
        place(cfg_req.dword, bxc_pkg::OFF_SERR_MASK, serr_mask_reg & bxc_pkg::SERR_MASK_WRITABLE) | // [R15]
        place(cfg_req.dword, bxc_pkg::OFF_GPIO_DATA, gpio_data_reg);
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cfg_ack_reg <= 1'b0;
      cfg_rdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      cfg_ack_reg <= cfg_ack_next;
      cfg_rdata_reg <= cfg_rdata_next;
    end
  end

  // ==========================================================
  // arbiter, its grant flops feed the ports directly
  bxc_tier_arbiter u_arbiter (
    .clock(clock),
    .rstn(rstn),
    .ce(ce),
    .soft_reset(soft_rst), // [R2]
    .req({bridge_req, secondary_req}),
    .high_tier(arb_tier_reg[bxc_pkg::ARB_BRIDGE_BIT:0]), // [R6] [R7]
    .grant_reg(grant_vec)
  );

  assign secondary_grant = grant_vec[8:0];
  assign bridge_grant = grant_vec[9];
  assign cfg_ack = cfg_ack_reg;
  assign cfg_rdata = cfg_rdata_reg;
  assign primary_system_error_out = serr_reg;
  assign gpio_out = gpio_out_reg;
  assign gpio_oe = gpio_oe_reg;
  assign self_reset_out = self_reset_reg;
  assign secondary_bus_reset_out = sec_bus_reset_reg;

endmodule

//--- testbench/bxc_ext_regs_assertions.sv
// concurrent checks on the extension control register ports
`timescale 1ns/1ps
module bxc_ext_regs_assertions (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // configuration access
  input wire logic cfg_valid,
  input wire bxc_pkg::bxc_cfg_req_t cfg_req,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  // arbitration
  input wire logic [8:0] secondary_req,
  input wire logic bridge_req,
  input wire logic [8:0] secondary_grant,
  input wire logic bridge_grant,
  // errors, gpio, resets
  input wire bxc_pkg::bxc_err_event_t err_event,
  input wire logic primary_system_error_out,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe,
  input wire logic self_reset_out,
  input wire logic secondary_bus_reset_out
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // ==========================================
  // config port
  AST_ACK: assert property (cfg_valid |=> cfg_ack) else $error("access not acked");
  AST_NO_ACK: assert property (!cfg_valid |=> !cfg_ack) else $error("ack without access");
  AST_DIAG_RD: assert property (cfg_valid && !cfg_req.write && cfg_req.dword == 6'h10
    |=> cfg_rdata[15:8] == 8'h00) else $error("diagnostic byte not zero");
  AST_ARB_RSVD: assert property (cfg_valid && !cfg_req.write && cfg_req.dword == 6'h10
    |=> cfg_rdata[31:26] == 6'h00) else $error("arbiter reserved bits set");
  AST_MASK_RSVD: assert property (cfg_valid && !cfg_req.write && cfg_req.dword == 6'h19
    |=> !cfg_rdata[7] && !cfg_rdata[0]) else $error("mask reserved bits set");
  // ==========================================
  // self reset: one cycle of set-up, then sixteen cycles; bit 6 outlives it
  AST_DIAG_GO: assert property (cfg_valid && cfg_req.write && cfg_req.dword == 6'h10 &&
    cfg_req.byte_en[1] && cfg_req.wdata[8] && !self_reset_out
    |-> ##2 self_reset_out && secondary_bus_reset_out) else $error("self reset not started");
  AST_SR_LEN: assert property ($rose(self_reset_out) |-> ##15 self_reset_out ##1 !self_reset_out)
    else $error("self reset length wrong");
  AST_SR_BUS: assert property (self_reset_out |-> secondary_bus_reset_out)
    else $error("secondary bus not in reset");
  // one cycle past the end the bus reset can only come from bit 6 itself
  AST_BIT6_KEEP: assert property ($fell(self_reset_out) |=> secondary_bus_reset_out)
    else $error("bridge control bit lost");
  // ==========================================
  // arbiter, system error, gpio
  AST_ONEHOT: assert property ($onehot0({bridge_grant, secondary_grant}))
    else $error("more than one grant");
  AST_GRANT_REQ: assert property (|{bridge_grant, secondary_grant}
    |-> ({bridge_grant, secondary_grant} & $past({bridge_req, secondary_req})) != 10'h000)
    else $error("grant without request");
  AST_SERR_CAUSE: assert property (primary_system_error_out |-> $past(err_event) != 6'h00)
    else $error("system error without event");
  AST_GPIO_IN: assert property ((gpio_out & ~gpio_oe) == 4'h0)
    else $error("input pin driven");
endmodule

bind bxc_ext_regs bxc_ext_regs_assertions chk_u (.clock(clock), .rstn(rstn), .cfg_valid(cfg_valid),
  .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .secondary_req(secondary_req),
  .bridge_req(bridge_req), .secondary_grant(secondary_grant), .bridge_grant(bridge_grant),
  .err_event(err_event), .primary_system_error_out(primary_system_error_out), .gpio_out(gpio_out),
  .gpio_oe(gpio_oe), .self_reset_out(self_reset_out), .secondary_bus_reset_out(secondary_bus_reset_out));

//--- testbench/bxc_ext_regs_bench.sv
// self-checking bench for the extension control registers
`timescale 1ns/1ps
module bxc_ext_regs_bench;
  // ==========================================
  // signals
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic cfg_valid = 1'b0;
  bxc_pkg::bxc_cfg_req_t cfg_req = '0;
  logic cfg_ack;
  logic [31:0] cfg_rdata;
  logic [8:0] secondary_req = '0;
  logic bridge_req = 1'b0;
  logic [8:0] secondary_grant;
  logic bridge_grant;
  logic serr_global_enable = 1'b1;
  bxc_pkg::bxc_err_event_t err_event = '0;
  logic primary_system_error_out;
  logic [3:0] gpio_dir_output = 4'h0;
  logic [3:0] gpio_out;
  logic [3:0] gpio_oe;
  logic self_reset_out;
  logic secondary_bus_reset_out;
  int fails = 0;
  int n_tests = 0;
  int seed = 80539;
  logic [9:0] exp_q[$];
  logic [3:0] gm = 4'h0;
  logic [9:0] g;
  logic [7:0] d;
  logic [5:0] ev;
  wire [9:0] grant_all = {bridge_grant, secondary_grant};

  always #12.5 clock = ~clock;

  bxc_ext_regs dut_u (.clock(clock), .rstn(rstn), .ce(ce), .cfg_valid(cfg_valid), .cfg_req(cfg_req),
    .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .secondary_req(secondary_req), .bridge_req(bridge_req),
    .secondary_grant(secondary_grant), .bridge_grant(bridge_grant),
    .serr_global_enable(serr_global_enable), .err_event(err_event),
    .primary_system_error_out(primary_system_error_out), .gpio_dir_output(gpio_dir_output),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .self_reset_out(self_reset_out),
    .secondary_bus_reset_out(secondary_bus_reset_out));

  // ==========================================
  // tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // expected lane byte is queued when the access is issued; writes read back zero
  task automatic cfg(input logic w, input logic [7:0] off, input logic [7:0] dat, input logic [7:0] exp);
    @(posedge clock);
    cfg_valid <= 1'b1;
    cfg_req <= '{w, off[7:2], 4'h1 << off[1:0], {4{dat}}};
    exp_q.push_back({off[1:0], w ? 8'h00 : exp});
    @(posedge clock);
    cfg_valid <= 1'b0;
  endtask

  task automatic pulse(input logic [5:0] e, input logic en, input logic exp);
    @(posedge clock);
    err_event <= e;
    serr_global_enable <= en;
    @(posedge clock);
    err_event <= '0;
    #1;
    check({15'h0, primary_system_error_out}, {15'h0, exp});
  endtask

  // pins stay put unless a one asks; low beats high; input pins keep their level
  task automatic gpio(input logic [7:0] v);
    cfg(1'b1, 8'h65, v, 8'h00);
    gm = (gm & ~gpio_dir_output) | ((gm | v[7:4]) & ~v[3:0] & gpio_dir_output);
    #1;
    check({12'h0, gpio_out}, {12'h0, gm & gpio_dir_output});
    check({12'h0, gpio_oe}, {12'h0, gpio_dir_output});
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================
  // read data monitor
  always @(posedge clock) begin
    if (cfg_ack === 1'b1) begin
      check({8'h00, cfg_rdata[8 * exp_q[0][9:8] +: 8]}, {8'h00, exp_q[0][7:0]});
      void'(exp_q.pop_front());
    end
  end

  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    finish_test();
  end

  // ==========================================
  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    cfg(1'b0, 8'h41, 8'h00, 8'h00);
    cfg(1'b0, 8'h42, 8'h00, 8'h00);
    cfg(1'b0, 8'h43, 8'h00, 8'h02);
    cfg(1'b0, 8'h64, 8'h00, 8'h00);
    cfg(1'b0, 8'h65, 8'h00, 8'h00);
    cfg(1'b0, 8'h70, 8'h00, 8'h00);
    #1;
    check({12'h0, gpio_oe}, 16'h0000);
    // default tiers: only the bridge is high
    @(posedge clock);
    bridge_req <= 1'b1;
    secondary_req <= 9'h001;
    repeat (2) @(posedge clock);
    #1;
    check({6'h0, grant_all}, 16'h0200);
    @(posedge clock);
    bridge_req <= 1'b0;
    secondary_req <= 9'h000;
    cfg(1'b1, 8'h43, 8'hfc, 8'h00);
    cfg(1'b1, 8'h42, 8'h08, 8'h00);
    cfg(1'b0, 8'h43, 8'h00, 8'h00);
    cfg(1'b0, 8'h42, 8'h00, 8'h08);
    @(posedge clock);
    bridge_req <= 1'b1;
    secondary_req <= 9'h028;
    repeat (2) @(posedge clock);
    #1;
    check({6'h0, grant_all}, 16'h0008);
    @(posedge clock);
    secondary_req <= 9'h020;
    repeat (2) @(posedge clock);
    #1;
    g = grant_all;
    // low tier rotation starts just after line 9, so line 5 goes before the bridge
    check({6'h0, g}, 16'h0020);
    @(posedge clock);
    {bridge_req, secondary_req} <= 10'h220 & ~g;
    repeat (2) @(posedge clock);
    #1;
    check({6'h0, grant_all}, {6'h0, 10'h220 & ~g});
    @(posedge clock);
    bridge_req <= 1'b0;
    secondary_req <= 9'h000;
    // event mask: all off, all on, then random
    cfg(1'b1, 8'h64, 8'hff, 8'h00);
    cfg(1'b0, 8'h64, 8'h00, 8'h7e);
    for (int i = 0; i < 6; i++) pulse(6'h01 << i, 1'b1, 1'b0);
    cfg(1'b1, 8'h64, 8'h00, 8'h00);
    for (int i = 0; i < 6; i++) pulse(6'h01 << i, 1'b1, 1'b1);
    pulse(6'h3f, 1'b0, 1'b0);
    repeat (16) begin
      d = 8'($random(seed));
      ev = 6'($random(seed));
      cfg(1'b1, 8'h64, d, 8'h00);
      pulse(ev, 1'b1, |(ev & ~d[6:1]));
    end
    // gpio: inputs first, then outputs
    gpio(8'hf0);
    @(posedge clock);
    gpio_dir_output <= 4'hf;
    gpio(8'hf0);
    gpio(8'h0f);
    gpio(8'h30);
    gpio(8'h11);
    repeat (6) begin
      d = 8'($random(seed));
      gpio(d);
    end
    @(posedge clock);
    gpio_dir_output <= 4'h3;
    gpio(8'hcc);
    cfg(1'b0, 8'h65, 8'h00, 8'hcc);
    // self reset must clear the mask but keep bridge control bit 6
    cfg(1'b1, 8'h64, 8'h12, 8'h00);
    cfg(1'b1, 8'h41, 8'h01, 8'h00);
    repeat (2) @(posedge clock);
    #1;
    check({14'h0, self_reset_out, secondary_bus_reset_out}, 16'h0003);
    repeat (16) @(posedge clock);
    #1;
    check({14'h0, self_reset_out, secondary_bus_reset_out}, 16'h0001);
    cfg(1'b0, 8'h3e, 8'h00, 8'h40);
    cfg(1'b0, 8'h41, 8'h00, 8'h00);
    cfg(1'b0, 8'h43, 8'h00, 8'h02);
    cfg(1'b0, 8'h64, 8'h00, 8'h00);
    cfg(1'b1, 8'h3e, 8'h00, 8'h00);
    @(posedge clock);
    #1;
    check({15'h0, secondary_bus_reset_out}, 16'h0000);
    repeat (3) @(posedge clock);
    // an access that never got its acknowledge would otherwise go unnoticed
    check(16'(exp_q.size()), 16'h0000);
    finish_test();
  end
endmodule
